// ### hdl/isrr_byte_pair.sv
// staged 16-bit register: low byte buffered, loaded whole on high write
`timescale 1ns/10ps
module isrr_byte_pair #(
   parameter logic [15:0] RST = 16'h0000
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // byte writes
   input  wire logic        wr_low,
   input  wire logic        wr_high,
   input  wire logic [7:0]  wdata,
   // active value
   output logic      [15:0] value
);
   typedef struct packed {
      logic [7:0]  buf_lo;
      logic [15:0] val;
   } isrr_bp_t;
   isrr_bp_t s_q, s_d;

   // buffer holds the low byte until the high byte commits both
   always_comb begin
      s_d = s_q;
      if (wr_low) begin
         s_d.buf_lo = wdata;
      end
      if (wr_high) begin
         s_d.val = {wdata, s_q.buf_lo};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= {RST[7:0], RST};
      end else begin
         s_q <= s_d;
      end
   end
   assign value = s_q.val;

   property p_commit;
      @(posedge clk_sys) disable iff (!reset_n)
      wr_high |=> value == {$past(wdata), $past(s_q.buf_lo)};
   endproperty
   a_commit: assert property (p_commit) else $error("pair commit");

   property p_hold_low;
      @(posedge clk_sys) disable iff (!reset_n)
      (wr_low && !wr_high) |=> $stable(value);
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("low wrote value");
endmodule : isrr_byte_pair

// ### hdl/isrr_comparator.sv
// hysteresis comparator of proximity against two thresholds
`timescale 1ns/10ps
module isrr_comparator #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   // data and thresholds
   input  wire logic         sample,
   input  wire logic [W-1:0] prox,
   input  wire logic [W-1:0] th_high,
   input  wire logic [W-1:0] th_low,
   // output, high once above the high threshold
   output logic              above
);
   typedef struct packed {
      logic above;
   } isrr_cmp_t;
   isrr_cmp_t s_q, s_d;

   // between thresholds the previous decision holds, avoiding chatter
   always_comb begin
      s_d = s_q;
      if (sample && prox > th_high) begin
         s_d.above = 1'b1;
      end else if (sample && prox < th_low) begin
         s_d.above = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign above = s_q.above;

   property p_rise;
      @(posedge clk_sys) disable iff (!reset_n)
      (sample && prox > th_high) |=> above;
   endproperty
   a_rise: assert property (p_rise) else $error("no rise");

   property p_fall;
      @(posedge clk_sys) disable iff (!reset_n)
      (sample && prox < th_low && !(prox > th_high)) |=> !above;
   endproperty
   a_fall: assert property (p_fall) else $error("no fall");
endmodule : isrr_comparator

// ### hdl/isrr_result_regs.sv
// register side of the inductive sensor: thresholds, control, status, results
// Behaviour
// - upper low-threshold write loads full sixteen bits
// - upper low-threshold read returns active bits
// - pin function code selects interrupt pin source
// - power bit: clear standby, set active
// - status bit 7 shows oscillator stopped
// - status bit 6 low means data ready
// - status bit 5 low means wake-up triggered
// - status bit 4 low above high threshold
// - proximity result readable as two bytes
// - frequency counter low byte readable
// - results refresh only at proximity low read
// - lower threshold byte only buffers
// - frequency counter upper bytes readable after low
`timescale 1ns/10ps
`include "isrr_defs.svh"
module isrr_result_regs (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset_n,
   // register port: one access per request strobe
   input  wire isrr_pkg::isrr_req_t req,
   output logic               [7:0] rdata,
   // conversion engine
   input  wire isrr_pkg::isrr_conv_t conv,
   input  wire logic                conv_done,
   input  wire logic                oscillator_fault,
   input  wire logic         [15:0] th_high,
   output logic                     conversion_run_select,
   // interrupt pin, active level per function
   output logic                     interrupt_out_pin
);
   typedef struct packed {
      logic [2:0]           pinfn;
      logic                 run;
      logic                 ready_n;
      logic                 wake_n;
      isrr_pkg::isrr_conv_t snap;
      logic [7:0]           rdata;
   } isrr_st_t;
   isrr_st_t s_q, s_d;

   logic [15:0] th_low;
   logic        above;
   logic        wr_lo, wr_hi, fresh;
   logic        result_ready_low;

   ////////////////////////////////////////////////////////////////////////
   // low threshold and comparator
   assign wr_lo = req.wr && req.addr == `ISRR_OFF_LTH_LOW;
   assign wr_hi = req.wr && req.addr == `ISRR_OFF_LTH_UP;

   isrr_byte_pair #(.RST(`ISRR_RST_LTH)) u_lth (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .wr_low  (wr_lo),
      .wr_high (wr_hi),
      .wdata   (req.wdata),
      .value   (th_low)
   );

   // only conversions that actually ran feed the comparator
   assign fresh = conv_done && s_q.run;

   isrr_comparator #(.W(16)) u_cmp (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .sample  (fresh),
      .prox    (conv.prox),
      .th_high (th_high),
      .th_low  (th_low),
      .above   (above)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state: control writes, flags, snapshot, read data
   always_comb begin
      s_d = s_q;
      if (req.wr && req.addr == `ISRR_OFF_PINFN) begin
         s_d.pinfn = req.wdata[2:0];
      end
      if (req.wr && req.addr == `ISRR_OFF_PWR) begin
         s_d.run = req.wdata[0];
      end
      // ready is consumed by the snapshot read; a new result wins
      if (req.rd_start && req.addr == `ISRR_OFF_PROX_LO) begin
         s_d.snap    = conv;
         s_d.ready_n = 1'b1;
      end
      if (fresh) begin
         s_d.ready_n = 1'b0;
      end
      // wake-up only armed while the pin carries that function
      if (s_q.pinfn != `ISRR_FN_WAKE) begin
         s_d.wake_n = 1'b1;
      end else if (fresh && conv.prox > th_high) begin
         s_d.wake_n = 1'b0;
      end
      if (req.rd_start) begin
         case (req.addr)
            `ISRR_OFF_LTH_LOW:  s_d.rdata = th_low[7:0];
            `ISRR_OFF_LTH_UP:   s_d.rdata = th_low[15:8];
            `ISRR_OFF_PINFN:    s_d.rdata = {5'h00, s_q.pinfn};
            `ISRR_OFF_PWR:      s_d.rdata = {7'h00, s_q.run};
            `ISRR_OFF_STATUS: begin
               s_d.rdata = 8'h00;
               s_d.rdata[`ISRR_ST_OSC]  = oscillator_fault;
               s_d.rdata[`ISRR_ST_RDY]  = s_q.ready_n;
               s_d.rdata[`ISRR_ST_WAKE] = s_q.wake_n;
               s_d.rdata[`ISRR_ST_COMP] = !above;
            end
            `ISRR_OFF_PROX_LO:  s_d.rdata = conv.prox[7:0];
            `ISRR_OFF_PROX_HI:  s_d.rdata = s_q.snap.prox[15:8];
            `ISRR_OFF_FREQ_LO:  s_d.rdata = s_q.snap.freq[7:0];
            `ISRR_OFF_FREQ_MID: s_d.rdata = s_q.snap.freq[15:8];
            `ISRR_OFF_FREQ_HI:  s_d.rdata = s_q.snap.freq[23:16];
            default:            s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= {`ISRR_RST_PINFN, `ISRR_RST_PWR, 1'b1, 1'b1, 40'h0000000000,
                 8'h00};
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; unsupported pin codes leave the pin idle
   assign rdata                 = s_q.rdata;
   assign conversion_run_select = s_q.run;
   assign result_ready_low      = s_q.ready_n;
   always_comb begin
      case (s_q.pinfn)
         `ISRR_FN_READY: interrupt_out_pin = result_ready_low;
         `ISRR_FN_COMP:  interrupt_out_pin = !above;
         `ISRR_FN_WAKE:  interrupt_out_pin = s_q.wake_n;
         default:        interrupt_out_pin = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_upper_read;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_LTH_UP) |=>
         rdata == th_low[15:8];
   endproperty
   a_upper_read: assert property (p_upper_read) else $error("lth read");

   property p_run;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.wr && req.addr == `ISRR_OFF_PWR) |=>
         conversion_run_select == $past(req.wdata[0]);
   endproperty
   a_run: assert property (p_run) else $error("power bit");

   property p_ready;
      @(posedge clk_sys) disable iff (!reset_n)
      fresh |=> !s_q.ready_n;
   endproperty
   a_ready: assert property (p_ready) else $error("ready flag");

   property p_snap_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      !(req.rd_start && req.addr == `ISRR_OFF_PROX_LO) |=> $stable(s_q.snap);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("snap moved");

   property p_snap_take;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_PROX_LO) |=>
         s_q.snap == $past(conv);
   endproperty
   a_snap_take: assert property (p_snap_take) else $error("no snap");

   property p_pin_ready;
      @(posedge clk_sys) disable iff (!reset_n)
      s_q.pinfn == `ISRR_FN_READY |-> interrupt_out_pin == s_q.ready_n;
   endproperty
   a_pin_ready: assert property (p_pin_ready) else $error("pin fn");

   property p_wake_idle;
      @(posedge clk_sys) disable iff (!reset_n)
      s_q.pinfn != `ISRR_FN_WAKE |=> s_q.wake_n;
   endproperty
   a_wake_idle: assert property (p_wake_idle) else $error("wake flag");

   property p_freq_hi;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_FREQ_HI) |=>
         rdata == s_q.snap.freq[23:16];
   endproperty
   a_freq_hi: assert property (p_freq_hi) else $error("freq read");

   // status fields, each taken at the edge that starts the read
   property p_osc_read;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_STATUS) |=>
         rdata[`ISRR_ST_OSC] == $past(oscillator_fault);
   endproperty
   a_osc_read: assert property (p_osc_read) else $error("osc bit");

   property p_rdy_read;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_STATUS) |=>
         rdata[`ISRR_ST_RDY] == $past(s_q.ready_n);
   endproperty
   a_rdy_read: assert property (p_rdy_read) else $error("ready bit");

   property p_wake_read;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_STATUS) |=>
         rdata[`ISRR_ST_WAKE] == $past(s_q.wake_n);
   endproperty
   a_wake_read: assert property (p_wake_read) else $error("wake bit");

   property p_cmp_read;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_STATUS) |=>
         rdata[`ISRR_ST_COMP] == !$past(above);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("cmp bit");

   // result bytes: low proximity byte is live, the rest come from the snap
   property p_prox_lo;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_PROX_LO) |=>
         rdata == $past(conv.prox[7:0]);
   endproperty
   a_prox_lo: assert property (p_prox_lo) else $error("prox low");

   property p_prox_hi;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_PROX_HI) |=>
         rdata == s_q.snap.prox[15:8];
   endproperty
   a_prox_hi: assert property (p_prox_hi) else $error("prox high");

   property p_freq_lo;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_FREQ_LO) |=>
         rdata == s_q.snap.freq[7:0];
   endproperty
   a_freq_lo: assert property (p_freq_lo) else $error("freq low");

   property p_freq_mid;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_FREQ_MID) |=>
         rdata == s_q.snap.freq[15:8];
   endproperty
   a_freq_mid: assert property (p_freq_mid) else $error("freq mid");

   // lower threshold location reads the active byte, never the buffer
   property p_lth_lo;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_LTH_LOW) |=>
         rdata == th_low[7:0];
   endproperty
   a_lth_lo: assert property (p_lth_lo) else $error("lth low");

   property p_lth_keep;
      @(posedge clk_sys) disable iff (!reset_n)
      !wr_hi |=> $stable(th_low);
   endproperty
   a_lth_keep: assert property (p_lth_keep) else $error("lth moved");

   // pin source per function code
   property p_pin_cmp;
      @(posedge clk_sys) disable iff (!reset_n)
      s_q.pinfn == `ISRR_FN_COMP |-> interrupt_out_pin == !above;
   endproperty
   a_pin_cmp: assert property (p_pin_cmp) else $error("pin cmp");

   property p_pin_wake;
      @(posedge clk_sys) disable iff (!reset_n)
      s_q.pinfn == `ISRR_FN_WAKE |-> interrupt_out_pin == s_q.wake_n;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake");

   property p_pin_off;
      @(posedge clk_sys) disable iff (!reset_n)
      (s_q.pinfn != `ISRR_FN_READY && s_q.pinfn != `ISRR_FN_COMP &&
       s_q.pinfn != `ISRR_FN_WAKE) |-> interrupt_out_pin;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin off");

   // flags: read clears ready unless a result lands in the same cycle
   property p_rdy_clr;
      @(posedge clk_sys) disable iff (!reset_n)
      (req.rd_start && req.addr == `ISRR_OFF_PROX_LO && !fresh) |=>
         s_q.ready_n;
   endproperty
   a_rdy_clr: assert property (p_rdy_clr) else $error("ready clr");

   property p_wake_set;
      @(posedge clk_sys) disable iff (!reset_n)
      (s_q.pinfn == `ISRR_FN_WAKE && fresh && conv.prox > th_high) |=>
         !s_q.wake_n;
   endproperty
   a_wake_set: assert property (p_wake_set) else $error("wake set");

   // the power bit moves only on its own write
   property p_run_hold;
      @(posedge clk_sys) disable iff (!reset_n)
      !(req.wr && req.addr == `ISRR_OFF_PWR) |=>
         $stable(conversion_run_select);
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("power moved");
endmodule : isrr_result_regs

// ### include/isrr_defs.svh
// register offsets, field positions and reset values of the result block
`ifndef ISRR_DEFS_SVH
`define ISRR_DEFS_SVH
`define ISRR_OFF_LTH_LOW    8'h08
`define ISRR_OFF_LTH_UP     8'h09
`define ISRR_OFF_PINFN      8'h0A
`define ISRR_OFF_PWR        8'h0B
`define ISRR_OFF_STATUS     8'h20
`define ISRR_OFF_PROX_LO    8'h21
`define ISRR_OFF_PROX_HI    8'h22
`define ISRR_OFF_FREQ_LO    8'h23
`define ISRR_OFF_FREQ_MID   8'h24
`define ISRR_OFF_FREQ_HI    8'h25
`define ISRR_RST_LTH        16'h0000
`define ISRR_RST_PINFN      3'h0
`define ISRR_RST_PWR        1'h0
`define ISRR_FN_READY       3'h4
`define ISRR_FN_COMP        3'h2
`define ISRR_FN_WAKE        3'h1
`define ISRR_ST_OSC         7
`define ISRR_ST_RDY         6
`define ISRR_ST_WAKE        5
`define ISRR_ST_COMP        4
`endif

// ### include/isrr_pkg.sv
// types shared by the result block files
package isrr_pkg;
   typedef struct packed {
      logic [15:0] prox;
      logic [23:0] freq;
   } isrr_conv_t;
   typedef struct packed {
      logic        wr;
      logic        rd_start;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } isrr_req_t;
endpackage : isrr_pkg

// ### sim/isrr_host.sv
// host model: drives the register port of the result block
`timescale 1ns/10ps
module isrr_host (
   // clock
   input  wire logic                clk_sys,
   // register port
   output isrr_pkg::isrr_req_t      req,
   input  wire logic          [7:0] rdata
);
   initial req = '0;

   // one write; strobe held for exactly one sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      req <= '{wr: 1'b1, rd_start: 1'b0, addr: a, wdata: v};
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask : wr

   // one read; data taken once the answer edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      req <= '{wr: 1'b0, rd_start: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      req.rd_start <= 1'b0;
      #1 v = rdata;
   endtask : rd
endmodule : isrr_host

// ### sim/isrr_result_regs_bench.sv
// self-checking bench of the sensor result register block
`timescale 1ns/10ps
module isrr_result_regs_bench;
   logic                 clk_sys = 1'b0;
   logic                 reset_n = 1'b0;
   isrr_pkg::isrr_req_t  req;
   logic           [7:0] rdata;
   isrr_pkg::isrr_conv_t conv = '0;
   logic                 conv_done = 1'b0;
   logic                 osc_bad = 1'b0;
   logic          [15:0] th_high = 16'h8000;
   logic                 run;
   logic                 pin;
   int                   error_cnt = 0;
   int                   n_compared = 0;
   int                   cyc = 0;
   integer               seed = 32'h5DD5;
   logic           [7:0] a;
   logic           [7:0] b;
   logic          [15:0] p;
   logic          [23:0] f;

   // clock and hang guard; a run needs under two hundred cycles
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end

   isrr_result_regs u_dut (
      .clk_sys               (clk_sys),
      .reset_n               (reset_n),
      .req                   (req),
      .rdata                 (rdata),
      .conv                  (conv),
      .conv_done             (conv_done),
      .oscillator_fault      (osc_bad),
      .th_high               (th_high),
      .conversion_run_select (run),
      .interrupt_out_pin     (pin)
   );
   isrr_host u_host (.clk_sys(clk_sys), .req(req), .rdata(rdata));

   ////////////////////////////////////////////////////////////////////////
   // expectations and checking
   function automatic logic [7:0] st_exp(logic o, logic r, logic w, logic c);
      return {o, r, w, c, 4'h0};
   endfunction : st_exp
   // pin level per function code; wake mode is judged through status
   function automatic logic pin_exp(int c, logic r, logic k);
      return c == 4 ? r : (c == 2 ? k : 1'b1);
   endfunction : pin_exp
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask : chk
   // one register read compared whole against its expected byte
   task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
      logic [7:0] v;
      u_host.rd(a, v);
      chk(n, e, v);
   endtask : rchk
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   // one finished conversion offered to the block
   task automatic conv_pulse(input logic [15:0] px, input logic [23:0] fq);
      @(posedge clk_sys);
      conv <= '{prox: px, freq: fq};
      conv_done <= 1'b1;
      @(posedge clk_sys);
      conv_done <= 1'b0;
   endtask : conv_pulse

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1 chk("pin", 1'b1, pin);
      chk("run", 1'b0, run);
      rchk("lth_up", 8'h09, 8'h00);
      rchk("pinfn", 8'h0A, 8'h00);
      rchk("pwr", 8'h0B, 8'h00);
      rchk("unmapped", 8'h30, 8'h00);
      rchk("status", 8'h20, st_exp(0, 1, 1, 1));
      $display("test reset done");
      // random thresholds; a lone lower byte must not take effect
      repeat (4) begin
         a = 8'($random(seed));
         b = 8'($random(seed));
         u_host.wr(8'h08, a);
         u_host.wr(8'h09, b);
         rchk("lth_up", 8'h09, b);
         u_host.wr(8'h08, ~a);
         rchk("lth_hold", 8'h09, b);
         rchk("lth_lo", 8'h08, a);
      end
      $display("test threshold done");
      u_host.wr(8'h0B, 8'h01);
      #1 chk("run", 1'b1, run);
      u_host.wr(8'h0A, 8'h01);
      p = 16'($random(seed)) | 16'h8001;
      f = 24'($random(seed));
      conv_pulse(p, f);
      rchk("status", 8'h20, st_exp(0, 0, 0, 0));
      chk("pin", 1'b0, pin);
      // every pin code except wake (1) while a result is pending and data is above high
      for (int i = 0; i < 8; i++) begin
         if (i != 1) begin
            u_host.wr(8'h0A, 8'(i));
            #1 chk("pin", pin_exp(i, 1'b0, 1'b0), pin);
         end
      end
      u_host.wr(8'h0A, 8'h04);
      rchk("prox_lo", 8'h21, p[7:0]);
      @(posedge clk_sys);
      conv <= '{prox: ~p, freq: ~f};
      rchk("prox_hi", 8'h22, p[15:8]);
      rchk("freq_lo", 8'h23, f[7:0]);
      rchk("freq_mid", 8'h24, f[15:8]);
      rchk("freq_hi", 8'h25, f[23:16]);
      rchk("status", 8'h20, st_exp(0, 1, 1, 0));
      chk("pin", 1'b1, pin);
      $display("test snapshot done");
      // low threshold 0x10F0; trailing lower byte stays buffered
      u_host.wr(8'h08, 8'hF0);
      u_host.wr(8'h09, 8'h10);
      u_host.wr(8'h08, 8'h00);
      u_host.wr(8'h0A, 8'h02);
      conv_pulse(16'h4000, f);
      rchk("cmp_hold", 8'h20, st_exp(0, 0, 1, 0));
      chk("pin", 1'b0, pin);
      conv_pulse(16'h10E0, f);
      rchk("cmp_low", 8'h20, st_exp(0, 0, 1, 1));
      chk("pin", 1'b1, pin);
      $display("test comparator done");
      @(posedge clk_sys);
      osc_bad <= 1'b1;
      rchk("osc", 8'h20, st_exp(1, 0, 1, 1));
      @(posedge clk_sys);
      osc_bad <= 1'b0;
      rchk("osc", 8'h20, st_exp(0, 0, 1, 1));
      // consume the pending result so standby starts with ready clear
      rchk("prox_lo", 8'h21, 8'hE0);
      // standby: conversions neither flag data nor move the comparator
      u_host.wr(8'h0B, 8'h00);
      #1 chk("run", 1'b0, run);
      conv_pulse(p, f);
      rchk("rdy_cmp", 8'h20, st_exp(0, 1, 1, 1));
      $display("test standby done");
      end_sim();
   end
endmodule : isrr_result_regs_bench
